/* bip_defines.vh */
`ifndef BIP_DEFINES_VH
`define BIP_DEFINES_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define BIP_ADDR_W 8
`define BIP_ADR_CFG0 8'h00
`define BIP_ADR_CFG11 8'h0b
`define BIP_ADR_CFG17 8'h11
`define BIP_ADR_LEVEL 8'h16
`define BIP_ADR_FALL 8'h1a
`define BIP_ADR_RISE 8'h1b
`define BIP_ADR_PRESS 8'h1c
`define BIP_ADR_IRQ_STAT 8'h20
`define BIP_ADR_IRQ_CLR 8'h21
`define BIP_ADR_IRQ_EN 8'h22
`define BIP_ADR_CTRL 8'h23

// ----------------------------------------
// field layout
// ----------------------------------------
`define BIP_CFG0_OUT_LO 10
`define BIP_CFG11_DIR_LO 16
`define BIP_CFG17_DIR_LO 2
`define BIP_CFG17_OUT_LO 6
`define BIP_LVL_LO 20
`define BIP_RISE2_BIT 6
`define BIP_CTRL_REFRESH 0

// ----------------------------------------
// direction codes and reset values
// ----------------------------------------
`define BIP_DIR_OUT 2'h0
`define BIP_DIR_PULLUP 2'h1
`define BIP_DIR_PULLDN 2'h2
`define BIP_DIR_PLAIN 2'h3
`define BIP_CFG0_RST 24'h000000
`define BIP_CFG11_RST 24'hff0000
`define BIP_CFG17_RST 24'h000034
`define BIP_NPIN 6
`define BIP_NBTN 21
`define BIP_NIRQ 3
`define BIP_BRIDGE_PIN 3

`endif

/* bip_button_io_port.v */
// How it works
// (RULE1) two-bit field: out, pull-up, pull-down, plain
// (RULE2) port usable only when serial enable low
// (RULE3) serial enable high hands pins to serial; here pin 3 stays on the bridge switch while bridgeMode is set
// (RULE4) pin 3 drives analog switch in bridge mode
// (RULE5) outputs from cfg0 bits 10-13, cfg17 6-7
// (RULE6) pins 4,5 reset as inputs, pin 4 pull-up
// (RULE7) chip-select resets device when serial disabled
// (RULE8) word 22: levels 20-23, rising pins 2,3
// (RULE9) extended falling, rising, pressed in 26-28
// (RULE10) bits 0-5 singles, 6-20 pairs in order
// (RULE11) pins 3 and 4 high set bit 14
// (RULE12) 21 inputs only with no outputs
// (RULE13) pair needs neither single pressed before
// (RULE14) recognised pair hides its two singles
// (RULE15) one pair at a time, others ignored
// (RULE16) several held only when pressed sequentially
// (RULE17) extended words refresh on program-memory entry
// (RULE18) software reads 26-28, not 22, with diodes
// (RULE19) two-stage sync before edge detection
`include "bip_defines.vh"

// ----------------------------------------
// limitations
// ----------------------------------------
// three or more buttons pressed in one sample are not resolved; the
// decode keeps one pair and reports the rest as held singles from the next sample, so firmware should
// debounce before trusting a lone refresh
// the extended words lag the pins until the next refresh strobe

module bip_button_io_port (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // register port
  input wire [7:0] regAddr,
  input wire [23:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [23:0] regRdata,
  // mode and events
  input wire serialPortEnable,
  input wire bridgeMode,
  input wire bridgeSwitch,
  input wire progMemEntry,
  input wire chipSelectOrReset,
  output wire deviceReset,
  // pins
  input wire [5:0] portPinIn,
  output reg [5:0] portPinOut,
  output reg [5:0] portPinOe,
  output reg [5:0] pullUpEn,
  output reg [5:0] pullDownEn,
  // interrupt
  output wire irq
);

  // ----------------------------------------
  // pair decoding
  // ----------------------------------------
  // bit order 6..20: 01 12 23 35 45 02 13 24 34 03 14 25 04 15 05
  // pins 3 and 4 must land on bit 14, so that pair trades with 35
  // a pair owns one bit in all three extended words, so a pair and
  // its two singles are never both set in one pressed-word snapshot
  function [5:0] pairMask;
    input [4:0] idx;
    begin
      case (idx)
        5'd6: pairMask = 6'h03;
        5'd7: pairMask = 6'h06;
        5'd8: pairMask = 6'h0c;
        5'd9: pairMask = 6'h28;
        5'd10: pairMask = 6'h30;
        5'd11: pairMask = 6'h05;
        5'd12: pairMask = 6'h0a;
        5'd13: pairMask = 6'h14;
        5'd14: pairMask = 6'h18; // see (RULE11)
        5'd15: pairMask = 6'h09;
        5'd16: pairMask = 6'h12;
        5'd17: pairMask = 6'h24;
        5'd18: pairMask = 6'h11;
        5'd19: pairMask = 6'h22;
        5'd20: pairMask = 6'h21;
        default: pairMask = 6'h00;
      endcase
    end
  endfunction

  function [1:0] dirOf;
    input [23:0] c11;
    input [23:0] c17;
    input integer p;
    begin
      if (p < 4) begin
        dirOf = c11[`BIP_CFG11_DIR_LO + 2 * p +: 2];
      end else begin
        dirOf = c17[`BIP_CFG17_DIR_LO + 2 * (p - 4) +: 2];
      end
    end
  endfunction

  // write strobe aimed at one address; shared by refresh and irq clear
  function wrHit;
    input we;
    input [7:0] addr;
    input [7:0] target;
    begin
      wrHit = we && (addr == target);
    end
  endfunction

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  reg [23:0] cfg0_reg;
  reg [23:0] cfg11_reg;
  reg [23:0] cfg17_reg;
  reg [2:0] irqStat_reg;
  reg [2:0] irqEn_reg;

  // pin sampling and level word
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  reg [5:0] prev_reg;
  reg [1:0] rise23_reg;
  reg [20:0] fall_reg;
  reg [20:0] rise_reg;
  reg [20:0] press_reg;
  reg [5:0] heldPrev_reg;
  reg [20:0] pressLive_reg;
  reg [20:0] riseAcc_reg;
  reg [20:0] fallAcc_reg;

  // decode scratch, rebuilt every cycle
  reg [20:0] pressLive_next;
  reg [20:0] riseNew;
  reg [20:0] fallNew;
  reg [5:0] dirOut;
  reg [5:0] outVal;
  reg [5:0] held;
  reg pairFound;
  reg [4:0] pairIdx;
  reg [5:0] pm;
  integer i;

  wire portActive = ~serialPortEnable; // see (RULE2)
  wire anyOutput = |dirOut;
  wire refresh = progMemEntry |
    (wrHit(regWr, regAddr, `BIP_ADR_CTRL) && regWdata[`BIP_CTRL_REFRESH]);
  // pin 3 leaves the port in bridge mode, see (RULE4)
  wire [5:0] usable = {2'b11, ~bridgeMode, 3'b111};

  // only while serial is off, see (RULE7)
  assign deviceReset = portActive & chipSelectOrReset;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg0_reg <= `BIP_CFG0_RST;
      cfg11_reg <= `BIP_CFG11_RST;
      cfg17_reg <= `BIP_CFG17_RST; // see (RULE6)
      irqEn_reg <= 3'h0;
    end else if (regWr) begin
      case (regAddr)
        `BIP_ADR_CFG0: cfg0_reg <= regWdata;
        `BIP_ADR_CFG11: cfg11_reg <= regWdata;
        `BIP_ADR_CFG17: cfg17_reg <= regWdata;
        `BIP_ADR_IRQ_EN: irqEn_reg <= regWdata[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  // output levels gathered from the two config words, see (RULE5)
  always @* begin
    outVal = {cfg17_reg[`BIP_CFG17_OUT_LO +: 2], cfg0_reg[`BIP_CFG0_OUT_LO +: 4]};
  end

  genvar g;
  generate
    for (g = 0; g < `BIP_NPIN; g = g + 1) begin : gPin
      wire [1:0] dirField;
      assign dirField = dirOf(cfg11_reg, cfg17_reg, g);

      // a pin lent to the bridge switch never counts as a port output
      always @* begin
        dirOut[g] = (dirField == `BIP_DIR_OUT) & usable[g];
      end

      // registered drivers; serial block owns the pins when enabled, except pin 3 in bridge mode, see (RULE3)
      // pulls stay off on outputs so a driven pin never fights its resistor
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          portPinOut[g] <= 1'b0;
          portPinOe[g] <= 1'b0;
          pullUpEn[g] <= 1'b0;
          pullDownEn[g] <= 1'b0;
        end else begin
          if (bridgeMode && g == `BIP_BRIDGE_PIN) begin
            // bridge switch wins over the port config, see (RULE4)
            portPinOe[g] <= 1'b1;
            portPinOut[g] <= bridgeSwitch;
          end else begin
            // see (RULE1)
            portPinOe[g] <= portActive & dirOut[g];
            portPinOut[g] <= outVal[g];
          end
          pullUpEn[g] <= portActive & usable[g] & (dirField == `BIP_DIR_PULLUP);
          pullDownEn[g] <= portActive & usable[g] & (dirField == `BIP_DIR_PULLDN);
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // input sampling
  // ----------------------------------------
  // per-pin flops; only the second stage feeds the decode, see (RULE19)
  // prev resets low to match the idle level, so no false edge follows reset
  generate
    for (g = 0; g < `BIP_NPIN; g = g + 1) begin : gSync
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
          prev_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= portPinIn[g];
          sync2_reg[g] <= sync1_reg[g];
          prev_reg[g] <= sync2_reg[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // button matrix decode
  // ----------------------------------------
  always @* begin
    held = sync2_reg & usable & {`BIP_NPIN{portActive}};
    pairFound = 1'b0;
    pairIdx = 5'd0;
    pm = 6'h00;
    pressLive_next = 21'h000000;
    // keep singles that were already held, see (RULE16)
    pressLive_next[5:0] = held & heldPrev_reg;
    // lowest-numbered matching new pair wins, see (RULE15)
    for (i = `BIP_NBTN - 1; i >= `BIP_NPIN; i = i - 1) begin
      pm = pairMask(i[4:0]);
      if ((held & pm) == pm && (heldPrev_reg & pm) == 6'h00) begin // see (RULE13)
        pairFound = 1'b1;
        pairIdx = i[4:0];
      end
    end
    // a standing pair persists while both held
    for (i = `BIP_NPIN; i < `BIP_NBTN; i = i + 1) begin
      pm = pairMask(i[4:0]);
      if (pressLive_reg[i] && (held & pm) == pm) begin
        pressLive_next[i] = 1'b1;
        pressLive_next[5:0] = pressLive_next[5:0] & ~pm;
      end
    end
    if (pairFound) begin
      pm = pairMask(pairIdx);
      pressLive_next[pairIdx] = 1'b1; // see (RULE11)
      pressLive_next[5:0] = pressLive_next[5:0] & ~pm; // see (RULE14)
    end else begin
      // new lone single only when at most one pin is new
      for (i = 0; i < `BIP_NPIN; i = i + 1) begin
        if (held[i] && !heldPrev_reg[i] && ((held & ~heldPrev_reg) == (6'h01 << i))) begin
          pressLive_next[i] = 1'b1;
        end
      end
    end
    // an output pin would short the diodes of every pair it belongs to,
    // so the pair bits are simply forced clear rather than decoded wrong
    // diode matrix needs all pins as inputs, see (RULE12)
    if (anyOutput) begin
      pressLive_next[20:6] = 15'h0000;
    end
    riseNew = pressLive_next & ~pressLive_reg;
    fallNew = pressLive_reg & ~pressLive_next;
  end

  // ----------------------------------------
  // status words
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      heldPrev_reg <= 6'h00;
      pressLive_reg <= 21'h000000;
      riseAcc_reg <= 21'h000000;
      fallAcc_reg <= 21'h000000;
      fall_reg <= 21'h000000;
      rise_reg <= 21'h000000;
      press_reg <= 21'h000000;
      rise23_reg <= 2'h0;
    end else begin
      heldPrev_reg <= held;
      pressLive_reg <= pressLive_next;
      // rising flags of pins 2 and 3, see (RULE8)
      rise23_reg <= sync2_reg[3:2] & ~prev_reg[3:2];
      // edges pile up between refreshes so a short tap is not lost;
      // pressed state is a snapshot, not an accumulation
      if (refresh) begin
        // published words update only here, see (RULE17)
        fall_reg <= fallAcc_reg | fallNew; // see (RULE9)
        rise_reg <= riseAcc_reg | riseNew;
        press_reg <= pressLive_next;
        riseAcc_reg <= 21'h000000;
        fallAcc_reg <= 21'h000000;
      end else begin
        riseAcc_reg <= riseAcc_reg | riseNew;
        fallAcc_reg <= fallAcc_reg | fallNew;
      end
    end
  end

  // ----------------------------------------
  // interrupt: fall, rise, refresh events
  // ----------------------------------------
  wire [2:0] irqEvt = {refresh, |riseNew, |fallNew};
  wire irqClr = wrHit(regWr, regAddr, `BIP_ADR_IRQ_CLR);

  // set wins over a clear in the same cycle; each bit stands alone
  generate
    for (g = 0; g < `BIP_NIRQ; g = g + 1) begin : gIrq
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          irqStat_reg[g] <= 1'b0;
        end else if (irqEvt[g]) begin
          irqStat_reg[g] <= 1'b1;
        end else if (irqClr && regWdata[g]) begin
          irqStat_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(irqStat_reg & irqEn_reg);

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // data stands one cycle and returns to zero, so a stale word can
  // never be mistaken for a fresh read
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 24'h000000;
    end else if (regRd) begin
      case (regAddr)
        `BIP_ADR_CFG0: regRdata <= cfg0_reg;
        `BIP_ADR_CFG11: regRdata <= cfg11_reg;
        `BIP_ADR_CFG17: regRdata <= cfg17_reg;
        `BIP_ADR_LEVEL: regRdata <= {sync2_reg[3:0], 12'h000, rise23_reg, 6'h00}; // see (RULE8)
        `BIP_ADR_FALL: regRdata <= {3'h0, fall_reg}; // see (RULE10)
        `BIP_ADR_RISE: regRdata <= {3'h0, rise_reg};
        `BIP_ADR_PRESS: regRdata <= {3'h0, press_reg};
        `BIP_ADR_IRQ_STAT: regRdata <= {21'h000000, irqStat_reg};
        `BIP_ADR_IRQ_EN: regRdata <= {21'h000000, irqEn_reg};
        default: regRdata <= 24'h000000;
      endcase
    end else begin
      regRdata <= 24'h000000;
    end
  end

endmodule // bip_button_io_port

/* bip_props.sv */
module bip_props (
  // watched ports
  input wire clk,
  input wire arst_n,
  input wire regRd,
  input wire [23:0] regRdata,
  input wire serialPortEnable,
  input wire bridgeMode,
  input wire bridgeSwitch,
  input wire chipSelectOrReset,
  input wire deviceReset,
  input wire [5:0] portPinOut,
  input wire [5:0] portPinOe,
  input wire [5:0] pullUpEn,
  input wire [5:0] pullDownEn
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // checks
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_CS_RST: assert property (chipSelectOrReset && !serialPortEnable |-> deviceReset)
    else $error("reset pin ignored");
  AST_SPI_NORST: assert property (serialPortEnable |-> !deviceReset)
    else $error("reset while serial");
  AST_SPI_OFF: assert property (serialPortEnable [*2] |->
    portPinOe == 6'h00 && pullUpEn == 6'h00 && pullDownEn == 6'h00)
    else $error("port active while serial");
  AST_BRIDGE: assert property (bridgeMode && !serialPortEnable |=>
    portPinOe[3] && portPinOut[3] == $past(bridgeSwitch))
    else $error("pin 3 not following switch");
  AST_OE_PULL: assert property ((portPinOe & (pullUpEn | pullDownEn)) == 6'h00)
    else $error("pull on output");
  AST_PULL_BOTH: assert property ((pullUpEn & pullDownEn) == 6'h00)
    else $error("both pulls on");
  AST_RD_IDLE: assert property (!$past(regRd) |-> regRdata == 24'h000000)
    else $error("read data outside slot");
  AST_RST_PIN4: assert property ($rose(arst_n) && !serialPortEnable |=>
    pullUpEn[4] && portPinOe[5:4] == 2'h0)
    else $error("pins 4 5 not inputs after reset");
endmodule // bip_props

bind bip_button_io_port bip_props u_props (.clk, .arst_n, .regRd, .regRdata, .serialPortEnable,
  .bridgeMode, .bridgeSwitch, .chipSelectOrReset, .deviceReset, .portPinOut, .portPinOe,
  .pullUpEn, .pullDownEn);

/* bip_button_model.sv */
module bip_button_model (
  // buttons, high while pressed
  input wire [5:0] press,
  // block side
  input wire [5:0] portPinOut,
  input wire [5:0] portPinOe,
  input wire [5:0] pullUpEn,
  output wire [5:0] pinLevel
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // pin levels
  // ----
  // board pull-downs hold released plain inputs low
  assign pinLevel = (portPinOe & portPinOut) | (~portPinOe & (press | pullUpEn));
endmodule // bip_button_model

/* test_button_io_port.sv */
module test_button_io_port;
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // wiring
  // ----
  logic clk, arst_n, regWr, regRd, serialPortEnable, bridgeMode, bridgeSwitch;
  logic progMemEntry, chipSelectOrReset, deviceReset, irq;
  logic [7:0] regAddr;
  logic [23:0] regWdata, regRdata, d;
  logic [5:0] press, portPinIn, portPinOut, portPinOe, pullUpEn, pullDownEn;
  int errorCnt, compares;
  wire [23:0] pins = {portPinOe, portPinOe & portPinOut, pullUpEn, pullDownEn};
  // cfg0, cfg11, cfg17, expected pins
  logic [95:0] rows [4] = '{96'h002800_000000_000034_3ca400, 96'h003c00_550000_0000c0_c303c0,
    96'h000000_aa0000_000018_00081f, 96'h000000_ff0000_00003c_000000};

  bip_button_io_port u_dut (.clk, .arst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .serialPortEnable, .bridgeMode, .bridgeSwitch, .progMemEntry, .chipSelectOrReset,
    .deviceReset, .portPinIn, .portPinOut, .portPinOe, .pullUpEn, .pullDownEn, .irq);
  bip_button_model u_btn (.press, .portPinOut, .portPinOe, .pullUpEn, .pinLevel(portPinIn));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
    @(posedge clk);
  endtask
  task automatic refresh;
    progMemEntry <= 1'b1;
    @(posedge clk);
    progMemEntry <= 1'b0;
    tick(2);
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d errors %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    #2000000;
    errorCnt++;
    end_sim;
  end

  initial begin
    {regWr, regRd, serialPortEnable, bridgeMode, bridgeSwitch, progMemEntry} = '0;
    {chipSelectOrReset, regAddr, regWdata, press, arst_n} = '0;
    errorCnt = 0;
    compares = 0;
    tick(6);
    arst_n <= 1'b1;
    tick(1);
    rd(8'h0b);
    chk(d, 24'hff0000);
    rd(8'h11);
    chk(d, 24'h000034);
    chk(pins, 24'h000400);
    rd(8'h30);
    chk(d, 24'h000000);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(8'h00, rows[i][95:72]);
      wr(8'h0b, rows[i][71:48]);
      wr(8'h11, rows[i][47:24]);
      #1 chk(pins, rows[i][23:0]);
      rd(8'h0b);
      chk(d, rows[i][71:48]);
    end
    $display("config table done");
    wr(8'h0b, 24'h000000);
    serialPortEnable <= 1'b1;
    chipSelectOrReset <= 1'b1;
    tick(2);
    #1 chk(pins, 24'h000000);
    chk(deviceReset, 1'b0);
    serialPortEnable <= 1'b0;
    bridgeMode <= 1'b1;
    bridgeSwitch <= 1'b1;
    tick(2);
    #1 chk(pins[23:12] & 12'h208, 12'h208);
    chk(deviceReset, 1'b1);
    bridgeMode <= 1'b0;
    chipSelectOrReset <= 1'b0;
    wr(8'h0b, 24'hff0000);
    $display("serial and bridge done");
    wr(8'h22, 24'h000007);
    press <= 6'h04;
    tick(4);
    rd(8'h16);
    chk(d[23:20], 4'h4);
    press <= 6'h00;
    tick(4);
    refresh;
    // pair pressed together, neither single held before
    press <= 6'h18;
    tick(4);
    refresh;
    rd(8'h1b);
    chk(d, 24'h004000);
    rd(8'h1c);
    chk(d, 24'h004000);
    $display("pair test done");
    #1 chk(irq, 1'b1);
    wr(8'h22, 24'h000000);
    #1 chk(irq, 1'b0);
    wr(8'h21, 24'h000007);
    wr(8'h22, 24'h000007);
    #1 chk(irq, 1'b0);
    $display("interrupt test done");
    end_sim;
  end
endmodule // test_button_io_port
